// file: bench/bwl_bridge_regs_tb.sv
// Self-checking bench for the bridge window and latency registers
`timescale 1ns/1ns
`include "bwl_map.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", nm, e, g); end end
module bwl_bridge_regs_tb
    import bwl_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [0:0] cfg_func = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h00000000;
    logic [31:0] cfg_rdata;
    logic cfg_rd_ack;
    logic [7:0] pri = 8'h06;
    logic [1:0][7:0] sec = {8'h10, 8'h05};
    logic [1:0][7:0] subv = {8'h10, 8'h08};
    logic cfgc_valid = 1'b0;
    logic [7:0] cfgc_bus = 8'h00;
    logic [1:0] cfgc_fwd;
    logic [1:0] cfgc_type0;
    logic [1:0][1:0] bridge_pf_sel = '0;
    logic pri_mem_valid = 1'b0;
    logic [31:0] pri_mem_addr = 32'h00000000;
    logic [1:0] pri_mem_claim;
    logic [1:0] pri_mem_win;
    logic [1:0] pri_mem_pf;
    logic [1:0] sec_mem_valid = 2'b00;
    logic [1:0][31:0] sec_mem_addr = '0;
    logic [1:0] sec_mem_up;
    logic [1:0] st;
    logic [1:0] bz;
    logic [1:0] dd;
    logic [1:0] term;
    logic [1:0] last;
    logic [1:0] go = 2'b00;
    logic cclk_tick;
    logic [31:0] wv[4] = '{32'h00100ABC, 32'h00101FFF, 32'h00200123, 32'h00200FFF};
    logic [31:0] ma[7] = '{32'h000FFFFF, 32'h00100000, 32'h00101FFF, 32'h00102000, 32'h00200000,
                           32'h00200FFF, 32'h00000000};
    int fails = 0;
    int compares = 0;
    int cyc = 0;

    always #2 clk = ~clk;

    bwl_bridge_regs #(.CCLK_DIV(2)) bwl_bridge_regs_i (.clk(clk), .reset(reset), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rd_ack(cfg_rd_ack), .pri_bus_num(pri), .sec_bus_num(sec),
        .cfgc_valid(cfgc_valid), .cfgc_bus(cfgc_bus), .cfgc_fwd(cfgc_fwd), .cfgc_type0(cfgc_type0),
        .bridge_pf_sel(bridge_pf_sel), .pri_mem_valid(pri_mem_valid), .pri_mem_addr(pri_mem_addr),
        .pri_mem_claim(pri_mem_claim), .pri_mem_win(pri_mem_win), .pri_mem_pf(pri_mem_pf),
        .sec_mem_valid(sec_mem_valid), .sec_mem_addr(sec_mem_addr), .sec_mem_up(sec_mem_up),
        .init_start(st), .init_busy(bz), .init_dphase_done(dd), .init_term_req(term),
        .init_last_phase(last), .cclk_tick(cclk_tick));

    for (genvar g = 0; g < 2; g++) begin : fn
        bwl_init_model bwl_init_model_i (.clk(clk), .go(go[g]), .gap(4'h2), .term_req(term[g]),
            .last_phase(last[g]), .start(st[g]), .busy(bz[g]), .dphase_done(dd[g]));
    end

    function automatic logic hit(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        return (((lo | hi) & 32'hFFFFF000) != 0) && (a >= (lo & 32'hFFFFF000)) && (a <= (hi | 32'h00000FFF));
    endfunction

    task automatic wr(input logic f, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge clk);
        cfg_func = f;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask

    task automatic rd(input logic f, input logic [7:0] a, input logic [31:0] e);
        @(negedge clk);
        cfg_func = f;
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge clk);
        cfg_rd = 1'b0;
        `CHK("rd_ack", 1'b1, cfg_rd_ack)
        `CHK("rdata", e, cfg_rdata)
    endtask

    task automatic mem(input logic [31:0] a, input logic [1:0] p);
        logic h0;
        logic h1;
        h0 = hit(a, wv[0], wv[1]);
        h1 = hit(a, wv[2], wv[3]);
        @(negedge clk);
        bridge_pf_sel = {~p, p};
        pri_mem_valid = 1'b1;
        pri_mem_addr = a;
        sec_mem_valid = 2'b11;
        sec_mem_addr = {a, a};
        @(negedge clk);
        pri_mem_valid = 1'b0;
        sec_mem_valid = 2'b00;
        `CHK("claim", {1'b0, h0 | h1}, pri_mem_claim)
        `CHK("pf", {1'b0, h0 ? p[0] : (h1 & p[1])}, pri_mem_pf)
        if (h0 | h1) `CHK("win", !h0, pri_mem_win[0])
        `CHK("up", {1'b1, !(h0 | h1)}, sec_mem_up)
    endtask

    task automatic lat_run(input int f, input int lat);
        int n;
        int k;
        n = 0;
        k = 0;
        @(negedge clk);
        go[f] <= 1'b1;
        @(negedge clk);
        go[f] <= 1'b0;
        do begin
            @(negedge clk);
            k++;
            `CHK("early_last", 1'b0, last[f])
            if (term[f] !== 1'b1 && cclk_tick === 1'b1) n++;
        end while (term[f] !== 1'b1 && k < 1000);
        `CHK("lat_ticks", lat, n)
        for (k = 0; k < 20; k++) begin
            @(negedge clk);
            if (dd[f] === 1'b1) break;
            `CHK("term_hold", 1'b1, term[f])
        end
        `CHK("last", 1'b1, last[f])
        `CHK("term_drop", 1'b0, term[f])
        @(negedge clk);
        `CHK("last_end", 1'b0, last[f])
    endtask

    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        repeat (12) @(negedge clk);
        reset = 1'b0;
        for (int f = 0; f < 2; f++) begin
            rd(f[0], `BWL_OFS_BUSNUM, {16'h0000, sec[f], pri});
            for (int i = 0; i < 4; i++) rd(f[0], 8'(`BWL_OFS_MB0 + 4 * i), 32'h00000000);
        end
        rd(1'b0, 8'h40, 32'h00000000);
        wr(1'b0, `BWL_OFS_MB0, 4'hF, 32'hFFFFFFFF);
        rd(1'b0, `BWL_OFS_MB0, 32'hFFFFF000);
        wr(1'b0, `BWL_OFS_MB0, 4'h1, 32'h000000AB);
        rd(1'b0, `BWL_OFS_MB0, 32'hFFFFF000);
        for (int i = 0; i < 4; i++) begin
            wr(1'b0, 8'(`BWL_OFS_MB0 + 4 * i), 4'hF, wv[i]);
            rd(1'b0, 8'(`BWL_OFS_MB0 + 4 * i), wv[i] & 32'hFFFFF000);
        end
        wr(1'b0, `BWL_OFS_BUSNUM, 4'h4, {8'h00, subv[0], 16'h0000});
        wr(1'b1, `BWL_OFS_BUSNUM, 4'h4, {8'h00, subv[1], 16'h0000});
        rd(1'b0, `BWL_OFS_BUSNUM, {8'h00, subv[0], sec[0], pri});
        rd(1'b1, `BWL_OFS_BUSNUM, {8'h00, subv[1], sec[1], pri});
        for (int b = 4; b < 18; b++) begin
            @(negedge clk);
            cfgc_valid = 1'b1;
            cfgc_bus = 8'(b);
            @(negedge clk);
            cfgc_valid = 1'b0;
            for (int f = 0; f < 2; f++) begin
                `CHK("fwd", 8'(b) != pri && 8'(b) >= sec[f] && 8'(b) <= subv[f], cfgc_fwd[f])
                `CHK("type0", 8'(b) != pri && 8'(b) == sec[f], cfgc_type0[f])
            end
        end
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 7; i++) mem(ma[i], 2'(p));
        end
        wr(1'b0, `BWL_OFS_BUSNUM, 4'h8, 32'h03000000);
        lat_run(0, 3);
        lat_run(1, 0);
        wr(1'b0, `BWL_OFS_BUSNUM, 4'h8, 32'h20000000);
        lat_run(0, 32);
        end_of_test();
    end
endmodule

// file: bench/bwl_init_model.sv
// Secondary initiator engine feeding one function's latency timer
`timescale 1ns/1ns
module bwl_init_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] gap,
    input wire logic term_req,
    input wire logic last_phase,
    output logic start,
    output logic busy,
    output logic dphase_done
);
    logic [3:0] cnt;

    initial begin
        start = 1'b0;
        busy = 1'b0;
        dphase_done = 1'b0;
        cnt = 4'h0;
    end

    // Frame start, steady data phases, stop when told the phase was last
    always @(negedge clk) begin
        start <= 1'b0;
        dphase_done <= 1'b0;
        if (go && !busy) begin
            start <= 1'b1;
            busy <= 1'b1;
            cnt <= gap;
        end else if (busy) begin
            if (last_phase) begin
                busy <= 1'b0;
            end else if (cnt == 4'h0) begin
                dphase_done <= 1'b1;
                cnt <= gap;
            end else begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

// file: design/bwl_bridge_regs.sv
// Bus number, latency timer and memory window registers of the bridge
`timescale 1ns/1ns
`include "bwl_map.svh"

// Notes on behaviour
// RULE1: A primary configuration cycle is forwarded when its bus lies from the secondary up to the subordinate bus.
// RULE2: Every bridge function keeps its own subordinate bus number, untouched by writes to another function.
// RULE3: When the bridge starts a secondary initiator frame, a counter loads the latency value and counts CCLK cycles.
// RULE4: If that counter runs out while the transaction is still going, the next completed data phase is the last.
// RULE5: Software should program the latency value to at least 20h so most transactions finish first.
// RULE6: Base and limit registers hold writable address bits 31 to 12, placing windows on 4-Kbyte boundaries.
// RULE7: Bits 11 to 0 of base and limit registers read zero and ignore writes.
// RULE8: A memory window claims cycles only while its base or its limit is nonzero.
// RULE9: Windows 0 and 1 are prefetchable or not by two separate select bits of bridge control.
// RULE10: Each window both passes primary cycles down and decides which secondary cycles go up.
// RULE11: An address is inside a window when not below the base and not above the limit padded with ones.
module bwl_bridge_regs
    import bwl_pkg::*;
#(
    parameter int NF = 2,
    parameter int FW = (NF > 1) ? $clog2(NF) : 1,
    parameter int unsigned CCLK_DIV = `BWL_CCLK_DIV
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [FW-1:0] cfg_func,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rd_ack,
    input wire logic [7:0] pri_bus_num,
    input wire logic [NF-1:0][7:0] sec_bus_num,
    input wire logic cfgc_valid,
    input wire logic [7:0] cfgc_bus,
    output logic [NF-1:0] cfgc_fwd,
    output logic [NF-1:0] cfgc_type0,
    input wire logic [NF-1:0][1:0] bridge_pf_sel,
    input wire logic pri_mem_valid,
    input wire logic [31:0] pri_mem_addr,
    output logic [NF-1:0] pri_mem_claim,
    output logic [NF-1:0] pri_mem_win,
    output logic [NF-1:0] pri_mem_pf,
    input wire logic [NF-1:0] sec_mem_valid,
    input wire logic [NF-1:0][31:0] sec_mem_addr,
    output logic [NF-1:0] sec_mem_up,
    input wire logic [NF-1:0] init_start,
    input wire logic [NF-1:0] init_busy,
    input wire logic [NF-1:0] init_dphase_done,
    output logic [NF-1:0] init_term_req,
    output logic [NF-1:0] init_last_phase,
    output logic cclk_tick
);
    bwl_byte_t sub_reg [NF];
    bwl_byte_t sub_next [NF];
    bwl_byte_t lat_reg [NF];
    bwl_byte_t lat_next [NF];
    bwl_win_t lo_reg [NF][2];
    bwl_win_t lo_next [NF][2];
    bwl_win_t hi_reg [NF][2];
    bwl_win_t hi_next [NF][2];
    logic [31:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;
    logic [NF-1:0] fwd_reg, fwd_next;
    logic [NF-1:0] t0_reg, t0_next;
    logic [7:0] div_reg, div_next;
    logic tick_reg, tick_next;
    logic func_ok;
    logic [7:0] word_addr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Byte lane of a register at a byte offset
    function automatic logic byte_hit(logic [7:0] a, logic [3:0] be, logic [7:0] ofs);
        return (a[7:2] == ofs[7:2]) && be[ofs[1:0]];
    endfunction

    function automatic bwl_byte_t lane_byte(logic [31:0] d, logic [7:0] ofs);
        return d[ofs[1:0]*8 +: 8];
    endfunction

    // Byte-enabled write keeping only the address bits
    function automatic bwl_win_t win_wr(bwl_win_t cur, logic [3:0] be, logic [31:0] d);
        logic [31:0] v;
        v = {cur, `BWL_LOW_ZERO};
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                v[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return v[31:`BWL_WIN_LSB];
    endfunction

    assign func_ok = (int'(cfg_func) < NF);
    assign word_addr = {cfg_addr[7:2], 2'b00};

    // Register writes
    always_comb begin
        for (int f = 0; f < NF; f++) begin
            sub_next[f] = sub_reg[f];
            lat_next[f] = lat_reg[f];
            for (int k = 0; k < 2; k++) begin
                lo_next[f][k] = lo_reg[f][k];
                hi_next[f][k] = hi_reg[f][k];
            end
        end
        if (cfg_wr && func_ok) begin
            if (byte_hit(cfg_addr, cfg_be, `BWL_OFS_SUB)) begin
                sub_next[cfg_func] = lane_byte(cfg_wdata, `BWL_OFS_SUB); // RULE2
            end
            if (byte_hit(cfg_addr, cfg_be, `BWL_OFS_LAT)) begin
                lat_next[cfg_func] = lane_byte(cfg_wdata, `BWL_OFS_LAT);
            end
            case (word_addr)
                `BWL_OFS_MB0: begin
                    lo_next[cfg_func][0] = win_wr(lo_reg[cfg_func][0], cfg_be, cfg_wdata); // RULE6
                end
                `BWL_OFS_ML0: begin
                    hi_next[cfg_func][0] = win_wr(hi_reg[cfg_func][0], cfg_be, cfg_wdata); // RULE6
                end
                `BWL_OFS_MB1: begin
                    lo_next[cfg_func][1] = win_wr(lo_reg[cfg_func][1], cfg_be, cfg_wdata); // RULE6
                end
                `BWL_OFS_ML1: begin
                    hi_next[cfg_func][1] = win_wr(hi_reg[cfg_func][1], cfg_be, cfg_wdata); // RULE6
                end
                default: begin
                end
            endcase
        end
    end

    // Register reads
    always_comb begin
        rdata_next = `BWL_RD_ZERO;
        ack_next = cfg_rd;
        if (cfg_rd && func_ok) begin
            case (word_addr)
                `BWL_OFS_BUSNUM: begin
                    rdata_next = {lat_reg[cfg_func], sub_reg[cfg_func], sec_bus_num[cfg_func], pri_bus_num};
                end
                `BWL_OFS_MB0: begin
                    rdata_next = {lo_reg[cfg_func][0], `BWL_LOW_ZERO}; // RULE7
                end
                `BWL_OFS_ML0: begin
                    rdata_next = {hi_reg[cfg_func][0], `BWL_LOW_ZERO}; // RULE7
                end
                `BWL_OFS_MB1: begin
                    rdata_next = {lo_reg[cfg_func][1], `BWL_LOW_ZERO}; // RULE7
                end
                `BWL_OFS_ML1: begin
                    rdata_next = {hi_reg[cfg_func][1], `BWL_LOW_ZERO}; // RULE7
                end
                default: begin
                    rdata_next = `BWL_RD_ZERO;
                end
            endcase
        end
    end

    // Configuration cycle forwarding
    always_comb begin
        for (int f = 0; f < NF; f++) begin
            fwd_next[f] = cfgc_valid && (cfgc_bus != pri_bus_num) // RULE1
                && (cfgc_bus >= sec_bus_num[f]) && (cfgc_bus <= sub_reg[f]);
            t0_next[f] = fwd_next[f] && (cfgc_bus == sec_bus_num[f]);
        end
    end

    // CCLK rate enable
    always_comb begin
        tick_next = (div_reg == 8'(CCLK_DIV - 1));
        div_next = tick_next ? '0 : div_reg + 8'h01;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int f = 0; f < NF; f++) begin
                sub_reg[f] <= `BWL_RST_BYTE;
                lat_reg[f] <= `BWL_RST_BYTE;
                for (int k = 0; k < 2; k++) begin
                    lo_reg[f][k] <= `BWL_RST_WIN;
                    hi_reg[f][k] <= `BWL_RST_WIN;
                end
            end
            rdata_reg <= `BWL_RD_ZERO;
            ack_reg <= 1'b0;
            fwd_reg <= '0;
            t0_reg <= '0;
            div_reg <= `BWL_RST_BYTE;
            tick_reg <= 1'b0;
        end else begin
            sub_reg <= sub_next;
            lat_reg <= lat_next;
            lo_reg <= lo_next;
            hi_reg <= hi_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            fwd_reg <= fwd_next;
            t0_reg <= t0_next;
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign cfg_rdata = rdata_reg;
    assign cfg_rd_ack = ack_reg;
    assign cfgc_fwd = fwd_reg;
    assign cfgc_type0 = t0_reg;
    assign cclk_tick = tick_reg;

    // Per-function timer and window decode
    for (genvar g = 0; g < NF; g++) begin : gen_func
        bwl_lat_if lif();
        bwl_win_if wif();
        assign lif.start = init_start[g];
        assign lif.busy = init_busy[g];
        assign lif.dphase_done = init_dphase_done[g];
        assign lif.tick = tick_reg; // RULE3
        assign lif.limit = lat_reg[g];
        assign init_term_req[g] = lif.term_req;
        assign init_last_phase[g] = lif.last_phase;
        assign wif.lo0 = lo_reg[g][0];
        assign wif.hi0 = hi_reg[g][0];
        assign wif.lo1 = lo_reg[g][1];
        assign wif.hi1 = hi_reg[g][1];
        assign wif.pf_sel = bridge_pf_sel[g];
        assign wif.pri_valid = pri_mem_valid;
        assign wif.pri_addr = pri_mem_addr;
        assign wif.sec_valid = sec_mem_valid[g];
        assign wif.sec_addr = sec_mem_addr[g];
        assign pri_mem_claim[g] = wif.claim;
        assign pri_mem_win[g] = wif.win;
        assign pri_mem_pf[g] = wif.pf;
        assign sec_mem_up[g] = wif.up;

        bwl_lat_timer u_lat (
            .clk(clk),
            .reset(reset),
            .t(lif.tmr)
        );

        bwl_win_decode u_win (
            .clk(clk),
            .reset(reset),
            .w(wif.dec)
        );
    end

    sequence base0_write_s;
        cfg_wr && cfg_func == '0 && cfg_be == 4'hF && word_addr == `BWL_OFS_MB0;
    endsequence

    sub_isolate_a: assert property (cfg_wr && cfg_func != '0 |=> $stable(sub_reg[0])) // RULE2
        else $error("other function write changed subordinate bus");
    win_store_a: assert property (base0_write_s |=> lo_reg[0][0] == $past(cfg_wdata[31:`BWL_WIN_LSB])) // RULE6
        else $error("window base not stored");
    low_zero_a: assert property (cfg_rd && word_addr == `BWL_OFS_ML1 |=> cfg_rd_ack && cfg_rdata[11:0] == '0) // RULE7
        else $error("low window bits not zero");
    fwd_above_a: assert property (cfgc_valid && cfgc_bus > sub_reg[0] |=> !cfgc_fwd[0]) // RULE1
        else $error("cycle above subordinate bus forwarded");
    fwd_inside_a: assert property (cfgc_valid && cfgc_bus != pri_bus_num && cfgc_bus > sec_bus_num[0] // RULE1
        && cfgc_bus <= sub_reg[0] |=> cfgc_fwd[0] && !cfgc_type0[0])
        else $error("cycle behind bridge not forwarded");

    // Register port checks
    sequence lat0_write_s;
        cfg_wr && cfg_func == '0 && cfg_be[3] && word_addr == `BWL_OFS_BUSNUM;
    endsequence
    sequence sub0_write_s;
        cfg_wr && cfg_func == '0 && cfg_be[2] && word_addr == `BWL_OFS_BUSNUM;
    endsequence

    lat_store_a: assert property (lat0_write_s |=> lat_reg[0] == lane_byte($past(cfg_wdata), `BWL_OFS_LAT)) // RULE3
        else $error("latency value not stored");
    sub_store_a: assert property (sub0_write_s |=> sub_reg[0] == lane_byte($past(cfg_wdata), `BWL_OFS_SUB)) // RULE2
        else $error("subordinate bus not stored");
    limit1_store_a: assert property (cfg_wr && cfg_func == '0 && cfg_be == 4'hF && word_addr == `BWL_OFS_ML1 // RULE6
        |=> hi_reg[0][1] == $past(cfg_wdata[31:`BWL_WIN_LSB]))
        else $error("window limit not stored");
    base_read_a: assert property (cfg_rd && cfg_func == '0 && word_addr == `BWL_OFS_MB0 // RULE7
        |=> cfg_rdata == {$past(lo_reg[0][0]), `BWL_LOW_ZERO})
        else $error("window base read wrong");
    read_ack_a: assert property (cfg_rd |=> cfg_rd_ack) // RULE7
        else $error("read not acknowledged");
    ack_pulse_a: assert property (!cfg_rd |=> !cfg_rd_ack && cfg_rdata == `BWL_RD_ZERO) // RULE7
        else $error("read data outside acknowledge");

    // Forwarding checks
    fwd_primary_a: assert property (cfgc_valid && cfgc_bus == pri_bus_num |=> cfgc_fwd == '0) // RULE1
        else $error("cycle for primary bus forwarded");
    fwd_type0_a: assert property (cfgc_valid && cfgc_bus != pri_bus_num && cfgc_bus == sec_bus_num[0] // RULE1
        && cfgc_bus <= sub_reg[0] |=> cfgc_fwd[0] && cfgc_type0[0])
        else $error("cycle for secondary bus not converted");
    fwd_below_a: assert property (cfgc_valid && cfgc_bus < sec_bus_num[0] |=> !cfgc_fwd[0]) // RULE1
        else $error("cycle below secondary bus forwarded");
    fwd_idle_a: assert property (!cfgc_valid |=> cfgc_fwd == '0 && cfgc_type0 == '0) // RULE1
        else $error("forward without configuration cycle");
endmodule

// file: design/bwl_lat_timer.sv
// Initiator latency timer for one secondary bus
`timescale 1ns/1ns
module bwl_lat_timer
    import bwl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    bwl_lat_if.tmr t
);
    bwl_lat_st_t state_reg, state_next;
    bwl_byte_t cnt_reg, cnt_next;
    logic term_reg, term_next;
    logic last_reg, last_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        last_next = 1'b0;
        case (state_reg)
            BWL_IDLE: begin
                if (t.start) begin
                    cnt_next = t.limit; // RULE3
                    state_next = (t.limit == '0) ? BWL_EXPIRED : BWL_RUN;
                end
            end
            BWL_RUN: begin
                if (!t.busy) begin
                    state_next = BWL_IDLE;
                end else if (t.tick) begin
                    cnt_next = cnt_reg - 8'h01; // RULE3
                    if (cnt_reg <= 8'h01) begin
                        cnt_next = '0;
                        state_next = BWL_EXPIRED;
                    end
                end
            end
            BWL_EXPIRED: begin
                if (!t.busy) begin
                    state_next = BWL_IDLE;
                end else if (t.dphase_done) begin
                    last_next = 1'b1; // RULE4
                    state_next = BWL_IDLE;
                end
            end
            default: begin
                state_next = BWL_IDLE;
            end
        endcase
        term_next = (state_next == BWL_EXPIRED); // RULE4
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= BWL_IDLE;
            cnt_reg <= `BWL_RST_BYTE;
            term_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            term_reg <= term_next;
            last_reg <= last_next;
        end
    end

    assign t.term_req = term_reg;
    assign t.last_phase = last_reg;

    sequence frame_start_s;
        state_reg == BWL_IDLE && t.start && t.limit != '0;
    endsequence
    sequence final_phase_s;
        term_reg && t.busy && t.dphase_done;
    endsequence

    lat_load_a: assert property (@(posedge clk) disable iff (reset) // RULE3
        frame_start_s |=> cnt_reg == $past(t.limit) && !term_reg)
        else $error("latency count not loaded at frame start");
    expire_term_a: assert property (@(posedge clk) disable iff (reset) // RULE4
        state_reg == BWL_RUN && t.busy && t.tick && cnt_reg == 8'h01 |=> term_reg && cnt_reg == '0)
        else $error("expiry did not raise termination request");
    last_phase_a: assert property (@(posedge clk) disable iff (reset) // RULE4
        final_phase_s |=> last_reg && !term_reg ##1 !last_reg)
        else $error("transaction not ended after next data phase");
endmodule

// file: design/bwl_win_decode.sv
// Memory window decode for both directions of one function
`timescale 1ns/1ns
module bwl_win_decode
    import bwl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    bwl_win_if.dec w
);
    logic claim_reg, claim_next;
    logic win_reg, win_next;
    logic pf_reg, pf_next;
    logic up_reg, up_next;
    logic open0, open1, p0, p1, s0, s1;

    always_comb begin
        open0 = bwl_win_open(w.lo0, w.hi0); // RULE8
        open1 = bwl_win_open(w.lo1, w.hi1); // RULE8
        p0 = w.pri_valid && open0 && bwl_in_win(w.pri_addr, w.lo0, w.hi0); // RULE11
        p1 = w.pri_valid && open1 && bwl_in_win(w.pri_addr, w.lo1, w.hi1); // RULE11
        s0 = open0 && bwl_in_win(w.sec_addr, w.lo0, w.hi0);
        s1 = open1 && bwl_in_win(w.sec_addr, w.lo1, w.hi1);
        claim_next = p0 || p1; // RULE10
        win_next = !p0 && p1;
        pf_next = p0 ? w.pf_sel[0] : (p1 && w.pf_sel[1]); // RULE9
        up_next = w.sec_valid && !(s0 || s1); // RULE10
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            claim_reg <= 1'b0;
            win_reg <= 1'b0;
            pf_reg <= 1'b0;
            up_reg <= 1'b0;
        end else begin
            claim_reg <= claim_next;
            win_reg <= win_next;
            pf_reg <= pf_next;
            up_reg <= up_next;
        end
    end

    assign w.claim = claim_reg;
    assign w.win = win_reg;
    assign w.pf = pf_reg;
    assign w.up = up_reg;

    closed_win_a: assert property (@(posedge clk) disable iff (reset) // RULE8
        w.pri_valid && !open0 && !open1 |=> !w.claim)
        else $error("closed window claimed a cycle");
    pf_select_a: assert property (@(posedge clk) disable iff (reset) // RULE9
        p0 |=> w.claim && !w.win && w.pf == $past(w.pf_sel[0]))
        else $error("window 0 claim or prefetch wrong");
    sec_pass_a: assert property (@(posedge clk) disable iff (reset) // RULE10
        w.sec_valid && !open0 && !open1 |=> w.up)
        else $error("secondary cycle not passed upstream");
endmodule

// file: shared/bwl_if.sv
// Carriers between the register block and its helpers
`timescale 1ns/1ns
interface bwl_lat_if
    import bwl_pkg::*;
();
    logic start;
    logic busy;
    logic dphase_done;
    logic tick;
    bwl_byte_t limit;
    logic term_req;
    logic last_phase;
    modport ctl(output start, busy, dphase_done, tick, limit, input term_req, last_phase);
    modport tmr(input start, busy, dphase_done, tick, limit, output term_req, last_phase);
endinterface

interface bwl_win_if
    import bwl_pkg::*;
();
    bwl_win_t lo0;
    bwl_win_t hi0;
    bwl_win_t lo1;
    bwl_win_t hi1;
    logic [1:0] pf_sel;
    logic pri_valid;
    logic [31:0] pri_addr;
    logic sec_valid;
    logic [31:0] sec_addr;
    logic claim;
    logic win;
    logic pf;
    logic up;
    modport src(output lo0, hi0, lo1, hi1, pf_sel, pri_valid, pri_addr, sec_valid, sec_addr,
                input claim, win, pf, up);
    modport dec(input lo0, hi0, lo1, hi1, pf_sel, pri_valid, pri_addr, sec_valid, sec_addr,
                output claim, win, pf, up);
endinterface

// file: shared/bwl_map.svh
// Register offsets, reset values and field positions
`ifndef BWL_MAP_SVH
`define BWL_MAP_SVH
`define BWL_OFS_BUSNUM 8'h18
`define BWL_OFS_SUB 8'h1A
`define BWL_OFS_LAT 8'h1B
`define BWL_OFS_MB0 8'h1C
`define BWL_OFS_ML0 8'h20
`define BWL_OFS_MB1 8'h24
`define BWL_OFS_ML1 8'h28
`define BWL_RST_BYTE 8'h00
`define BWL_RST_WIN 20'h00000
`define BWL_RD_ZERO 32'h00000000
`define BWL_WIN_LSB 12
`define BWL_LOW_ZERO 12'h000
`define BWL_LOW_FILL 12'hFFF
`define BWL_LAT_MIN 8'h20
`define BWL_CCLK_DIV 8
`endif

// file: shared/bwl_pkg.sv
// Types and window decode functions
package bwl_pkg;
    `include "bwl_map.svh"
    typedef logic [7:0] bwl_byte_t;
    typedef logic [19:0] bwl_win_t;
    typedef enum logic [1:0] {BWL_IDLE, BWL_RUN, BWL_EXPIRED} bwl_lat_st_t;

    function automatic logic bwl_win_open(bwl_win_t lo, bwl_win_t hi);
        return (lo != '0) || (hi != '0);
    endfunction

    function automatic logic bwl_in_win(logic [31:0] a, bwl_win_t lo, bwl_win_t hi);
        return (a >= {lo, `BWL_LOW_ZERO}) && (a <= {hi, `BWL_LOW_FILL});
    endfunction
endpackage
